// >>> hw/seq_pkg.sv
package seq_pkg;
   // bias-settle blanking window, in microseconds
   localparam int unsigned BLANK_TIME_US = 20;
   // clock period in nanoseconds
   localparam int unsigned CLK_PERIOD_NS = 10;
   // blanking window in cycles, rounded up
   localparam int unsigned BLANK_CYCLES = (BLANK_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // overtemperature mask at burst start, microseconds
   localparam int unsigned OT_BLANK_TIME_US = 10;
   localparam int unsigned OT_BLANK_CYCLES = (OT_BLANK_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // auto-recovery delay default, milliseconds
   localparam int unsigned RECOVERY_TIME_MS = 1000;
   localparam int unsigned RECOVERY_CYCLES = RECOVERY_TIME_MS * 100000;
   // counter width for all timers
   localparam int unsigned CNT_W = 28;
   // front-stage output codes
   localparam logic [1:0] FS_OFF = 2'h0;
   localparam logic [1:0] FS_ON = 2'h1;
   localparam logic [1:0] FS_HOLD = 2'h2;
   // reset value of the front-stage output
   localparam logic [1:0] FS_RESET = 2'h0;

   // operating states
   typedef enum logic [3:0] {
      ST_POR, ST_CHARGE, ST_WAIT_BULK, ST_RECHARGE, ST_RUN, ST_SKIP, ST_BURST,
      ST_BROWNOUT, ST_LATCH, ST_RECOVER, ST_OFFMODE
   } state_e;

   // supply comparator group
   typedef struct packed {
      logic above_reset;   // supply above supply_reset_level
      logic above_start;   // supply above supply_start_level
      logic above_low;     // supply above supply_low_level
   } supply_s;

   // fault detector group
   typedef struct packed {
      logic severe;        // severe_fault_input
      logic overload;      // overload or output short
      logic overtemp;      // overtemperature, maskable at burst start
   } fault_s;

   // block enable outputs
   typedef struct packed {
      logic analog_bias;      // bias for all analog blocks
      logic severe_fault_input_bias;     // bias for the overvoltage/overtemperature block
      logic fb_supply_bias;   // feedback and supply management bias
      logic startup_source;   // high-voltage start-up source charging
      logic dynamic_self_supply; // start-up source regulated in self-supply mode
      logic bridge_enable;    // bridge_gate_outputs allowed
      logic soft_start;       // one-cycle pulse: regular start with soft-start
   } enables_s;
endpackage

// >>> hw/resonant_controller_sequencer.sv
`timescale 1ns/10ps
// Summary of operation
// - supply reset level: bias all, start blanking
// - first start level sets front-stage enable on until supply reset
// - no bulk good: bridge off, self-supply
// - bulk good: recharge, start at level
// - bulk lost: bridge off, fault block unbiased
// - brown-out keeps front-stage enable high
// - waiting bulk good runs self-supply
// - bulk good returns: recharge, rebias, blank
// - restart only via soft-start, clean conditions
// - severe fault in run latches off
// - latch kept by self-supply, reset clears
// - overload stops, self-supply, recovery countdown
// - recovery expiry recharges, rebias, blanks, restarts
// - skip threshold stops pulses, minimal bias
// - skip-exit rebiases all, bridge burst
// - skip exit never uses start-up source
// - burst start masks overtemperature briefly
// - bulk low in burst: brown-out stop
// - brown-out from skip: front-stage hold level
// - supply low in skip enters off-mode
// - feedback release wakes, recharges, restarts
module resonant_controller_sequencer #(
   parameter int unsigned RECOVERY_DELAY = seq_pkg::RECOVERY_CYCLES
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire seq_pkg::supply_s supply_cmp,  // supply threshold comparators
   input wire logic bulk_voltage_good,       // brown-out detector result
   input wire logic feedback_skip,           // feedback at or below skip threshold
   input wire logic feedback_exit,           // feedback at or above skip-exit threshold
   input wire logic feedback_released,       // feedback allowed to rise in off-mode
   input wire seq_pkg::fault_s faults,       // fault detectors
   input wire logic off_mode_enable,         // off-mode option
   output seq_pkg::enables_s enables,        // block enables
   output logic [1:0] front_stage_enable_out, // front-stage enable level
   output seq_pkg::state_e state_out         // current state
);

   ////////////////////////////////////////////////////////////////////////////
   // input synchronisers

   // raw inputs packed as one vector
   localparam int unsigned IN_W = 11;
   logic [IN_W-1:0] raw_in;
   logic [IN_W-1:0] sync1_reg;
   logic [IN_W-1:0] sync2_reg;
   assign raw_in = {supply_cmp, bulk_voltage_good, feedback_skip, feedback_exit,
                    feedback_released, faults, off_mode_enable};

   // two-stage synchroniser, first stage read only by second
   // input synchronisation
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= raw_in;
         sync2_reg <= sync1_reg;
      end
   end

   // named views of the synchronised inputs
   seq_pkg::supply_s sup;
   seq_pkg::fault_s flt;
   logic bulk_ok;
   logic fb_skip;
   logic fb_exit;
   logic fb_rel;
   logic off_en;
   assign {sup, bulk_ok, fb_skip, fb_exit, fb_rel, flt, off_en} = sync2_reg;

   ////////////////////////////////////////////////////////////////////////////
   // timers

   seq_pkg::state_e state_reg;
   seq_pkg::state_e state_next;
   logic [seq_pkg::CNT_W-1:0] blank_reg;   // bias-settle blanking remaining
   logic [seq_pkg::CNT_W-1:0] ot_blank_reg; // overtemperature mask remaining
   logic [seq_pkg::CNT_W-1:0] rec_reg;     // auto-recovery remaining
   logic blank_start;                      // begin a blanking window
   logic blank_active;
   logic ot_masked;
   logic burst_start;
   logic started_reg;                      // start level already seen once

   assign blank_active = (blank_reg != '0);
   assign ot_masked = (ot_blank_reg != '0);
   assign burst_start = (state_reg == seq_pkg::ST_SKIP) && (state_next == seq_pkg::ST_BURST);

   // blanking window counter
   // blanking window timer
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         blank_reg <= '0;
      end else if (blank_start) begin
         blank_reg <= seq_pkg::CNT_W'(seq_pkg::BLANK_CYCLES);
      end else if (blank_active) begin
         blank_reg <= blank_reg - 1'b1;
      end
   end

   // overtemperature mask counter
   // burst start mask
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ot_blank_reg <= '0;
      end else if (burst_start) begin
         ot_blank_reg <= seq_pkg::CNT_W'(seq_pkg::OT_BLANK_CYCLES);
      end else if (ot_masked) begin
         ot_blank_reg <= ot_blank_reg - 1'b1;
      end
   end

   // auto-recovery countdown
   // recovery countdown load
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rec_reg <= '0;
      end else if (state_next == seq_pkg::ST_RECOVER && state_reg != seq_pkg::ST_RECOVER) begin
         rec_reg <= seq_pkg::CNT_W'(RECOVERY_DELAY);
      end else if (rec_reg != '0) begin
         rec_reg <= rec_reg - 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state machine

   // faults visible only once blanking is over
   logic ovl;
   logic sev;
   logic otp;
   assign ovl = flt.overload && !blank_active;
   assign sev = flt.severe && !blank_active;
   assign otp = flt.overtemp && !blank_active && !ot_masked;

   // next-state logic
   always_comb begin
      state_next = state_reg;
      blank_start = 1'b0;
      unique case (state_reg)
         seq_pkg::ST_POR: begin
            if (sup.above_reset) begin
               state_next = seq_pkg::ST_CHARGE;
               blank_start = 1'b1;
            end
         end
         // charge to start level
         seq_pkg::ST_CHARGE: begin
            if (sup.above_start && !blank_active) begin
               if (!bulk_ok) begin
                  state_next = seq_pkg::ST_WAIT_BULK;
               end else if (!sev && !ovl && !otp) begin
                  state_next = seq_pkg::ST_RUN;
               end
            end
         end
         // stop condition present after first start level
         seq_pkg::ST_WAIT_BULK: begin
            if (bulk_ok) begin
               state_next = seq_pkg::ST_RECHARGE;
               blank_start = 1'b1;
            end
         end
         // recharge then regular start
         seq_pkg::ST_RECHARGE: begin
            if (!bulk_ok) begin
               state_next = seq_pkg::ST_BROWNOUT;
            end else if (sup.above_start && !blank_active && !sev && !ovl && !otp) begin
               state_next = seq_pkg::ST_RUN;
            end
         end
         // normal switching
         seq_pkg::ST_RUN, seq_pkg::ST_BURST: begin
            if (sev || otp) begin
               state_next = seq_pkg::ST_LATCH;
            end else if (!bulk_ok) begin
               state_next = seq_pkg::ST_BROWNOUT;
            end else if (ovl) begin
               state_next = seq_pkg::ST_RECOVER;
            end else if (fb_skip) begin
               state_next = seq_pkg::ST_SKIP;
            end
         end
         // skip pause, minimal bias
         seq_pkg::ST_SKIP: begin
            if (!sup.above_low && off_en) begin
               state_next = seq_pkg::ST_OFFMODE;
            end else if (fb_exit) begin
               state_next = seq_pkg::ST_BURST;
            end
         end
         // brown-out stop, waiting for bulk good
         seq_pkg::ST_BROWNOUT: begin
            if (bulk_ok) begin
               state_next = seq_pkg::ST_RECHARGE;
               blank_start = 1'b1;
            end
         end
         seq_pkg::ST_LATCH: begin
            state_next = seq_pkg::ST_LATCH;
         end
         // auto-recovery wait
         seq_pkg::ST_RECOVER: begin
            if (rec_reg == seq_pkg::CNT_W'(1)) begin
               state_next = seq_pkg::ST_CHARGE;
               blank_start = 1'b1;
            end
         end
         seq_pkg::ST_OFFMODE: begin
            if (fb_rel) begin
               state_next = seq_pkg::ST_CHARGE;
               blank_start = 1'b1;
            end
         end
         default: begin
            state_next = seq_pkg::ST_POR;
         end
      endcase
      if (!sup.above_reset) begin
         state_next = seq_pkg::ST_POR;
         blank_start = 1'b0;
      end
   end

   // state register
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_reg <= seq_pkg::ST_POR;
      end else begin
         state_reg <= state_next;
      end
   end

   // remembers that the start level was crossed once
   // first start level
   always_ff @(posedge clk) begin
      if (!reset_n || !sup.above_reset) begin
         started_reg <= 1'b0;
      end else if (sup.above_start) begin
         started_reg <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registered outputs

   seq_pkg::enables_s en_next;
   logic [1:0] fs_next;
   logic from_skip_reg;  // brown-out entered from skip or burst

   // remember origin of a brown-out stop
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         from_skip_reg <= 1'b0;
      end else if (state_next == seq_pkg::ST_BROWNOUT && state_reg != seq_pkg::ST_BROWNOUT) begin
         from_skip_reg <= (state_reg == seq_pkg::ST_BURST) || (state_reg == seq_pkg::ST_SKIP);
      end
   end

   // output decode from the next state
   always_comb begin
      en_next = '0;
      fs_next = started_reg || sup.above_start ? seq_pkg::FS_ON : seq_pkg::FS_OFF;
      unique case (state_next)
         seq_pkg::ST_POR: begin
            fs_next = seq_pkg::FS_OFF;
         end
         seq_pkg::ST_CHARGE, seq_pkg::ST_RECHARGE: begin
            en_next = '{analog_bias: 1'b1, severe_fault_input_bias: 1'b1, fb_supply_bias: 1'b1,
                        startup_source: 1'b1, default: 1'b0};
         end
         seq_pkg::ST_WAIT_BULK: begin
            en_next = '{analog_bias: 1'b1, severe_fault_input_bias: 1'b1, fb_supply_bias: 1'b1,
                        dynamic_self_supply: 1'b1, default: 1'b0};
         end
         seq_pkg::ST_RUN, seq_pkg::ST_BURST: begin
            en_next = '{analog_bias: 1'b1, severe_fault_input_bias: 1'b1, fb_supply_bias: 1'b1,
                        bridge_enable: 1'b1, default: 1'b0};
            en_next.soft_start = (state_reg == seq_pkg::ST_CHARGE) ||
                                 (state_reg == seq_pkg::ST_RECHARGE);
         end
         seq_pkg::ST_SKIP: begin
            en_next.fb_supply_bias = 1'b1;
         end
         seq_pkg::ST_BROWNOUT: begin
            en_next = '{analog_bias: 1'b1, fb_supply_bias: 1'b1,
                        dynamic_self_supply: 1'b1, default: 1'b0};
            // front stage kept on, or at hold level when the stop came from skip or burst
            // origin flag is only current once the stop has been entered
            if (state_reg == seq_pkg::ST_BROWNOUT) begin
               fs_next = from_skip_reg ? seq_pkg::FS_HOLD : seq_pkg::FS_ON;
            end else begin
               fs_next = (state_reg == seq_pkg::ST_BURST || state_reg == seq_pkg::ST_SKIP) ?
                         seq_pkg::FS_HOLD : seq_pkg::FS_ON;
            end
         end
         seq_pkg::ST_LATCH, seq_pkg::ST_RECOVER, seq_pkg::ST_OFFMODE: begin
            en_next.dynamic_self_supply = 1'b1;
         end
         default: begin
            en_next = '0;
         end
      endcase
   end

   // output flip-flops
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         enables <= '0;
         front_stage_enable_out <= seq_pkg::FS_RESET;
         state_out <= seq_pkg::ST_POR;
      end else begin
         enables <= en_next;
         front_stage_enable_out <= fs_next;
         state_out <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   // bridge never on without bulk good, except a skip burst that checks bulk itself
   bridge_bulk_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
      ($rose(enables.bridge_enable) && state_out != seq_pkg::ST_BURST) |-> $past(bulk_ok))
      else $error("bridge enabled without bulk good");

   // latch persists while supply above reset level
   latch_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
      (state_reg == seq_pkg::ST_LATCH && sup.above_reset) |=> state_reg == seq_pkg::ST_LATCH)
      else $error("latch left early");

   // severe fault in run latches off
   severe_latch_a: assert property (@(posedge clk) disable iff (!reset_n)
      (state_reg == seq_pkg::ST_RUN && sev && sup.above_reset) |=> state_reg == seq_pkg::ST_LATCH)
      else $error("severe fault not latched");

   // skip exit never enables start-up source
   skip_no_source_a: assert property (@(posedge clk) disable iff (!reset_n)
      (state_reg == seq_pkg::ST_SKIP && state_next == seq_pkg::ST_BURST) |=> !enables.startup_source)
      else $error("start-up source on at skip exit");

   // no start while blanking
   blank_no_run_a: assert property (@(posedge clk) disable iff (!reset_n)
      (blank_active && state_reg == seq_pkg::ST_CHARGE) |=> state_reg != seq_pkg::ST_RUN)
      else $error("started during blanking");

   // brown-out from burst drives hold level
   hold_level_a: assert property (@(posedge clk) disable iff (!reset_n)
      (state_reg == seq_pkg::ST_BURST && state_next == seq_pkg::ST_BROWNOUT)
      |=> front_stage_enable_out == seq_pkg::FS_HOLD)
      else $error("hold level missing");

   // skip keeps feedback and supply bias on, with analog bias and bridge off
   skip_bias_a: assert property (@(posedge clk) disable iff (!reset_n)
      (state_out == seq_pkg::ST_SKIP) |-> (enables.fb_supply_bias && !enables.analog_bias
                                           && !enables.bridge_enable))
      else $error("skip bias wrong");

   // blanking starts at reset level crossing
   blank_load_a: assert property (@(posedge clk) disable iff (!reset_n)
      (state_reg == seq_pkg::ST_POR && sup.above_reset) |=> blank_active ##1 blank_active)
      else $error("blanking not started");

endmodule // resonant_controller_sequencer

// >>> verification/supply_fault_model.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// far side: supply, bulk and feedback comparators plus fault detectors
module supply_fault_model #(
   parameter logic [15:0] RESET_MV = 16'h1f40,   // supply_reset_level, plain default
   parameter logic [15:0] LOW_MV = 16'h2328,     // supply_low_level, plain default
   parameter logic [15:0] START_MV = 16'h2ee0,   // supply_start_level, plain default
   parameter logic [15:0] BROWN_MV = 16'h012c,   // brownout_level on bulk_sense
   parameter logic [15:0] SKIP_MV = 16'h0190,    // feedback skip threshold
   parameter logic [15:0] EXIT_MV = 16'h0258,    // feedback skip-exit threshold
   parameter logic [15:0] RELEASE_MV = 16'h05dc  // feedback counted as released
) (
   input wire logic [15:0] vcc_mv,       // supply voltage in millivolts
   input wire logic [15:0] bulk_mv,      // bulk_sense voltage
   input wire logic [15:0] fb_mv,        // feedback_input voltage
   input wire logic [2:0] fault_req,     // severe, overload, overtemp detectors
   output seq_pkg::supply_s supply_cmp,  // supply comparators
   output logic bulk_voltage_good,       // brown-out detector
   output logic feedback_skip,           // feedback at or below skip threshold
   output logic feedback_exit,           // feedback at or above exit threshold
   output logic feedback_released,       // feedback pulled well up
   output seq_pkg::fault_s faults        // fault detector outputs
);
   // comparators follow the levels with no hysteresis, the harshest case
   assign supply_cmp.above_reset = vcc_mv > RESET_MV;
   assign supply_cmp.above_start = vcc_mv > START_MV;
   assign supply_cmp.above_low = vcc_mv > LOW_MV;
   assign bulk_voltage_good = bulk_mv >= BROWN_MV;
   assign feedback_skip = fb_mv <= SKIP_MV;
   assign feedback_exit = fb_mv >= EXIT_MV;
   assign feedback_released = fb_mv > RELEASE_MV;
   assign faults = seq_pkg::fault_s'(fault_req);
endmodule // supply_fault_model

// >>> verification/resonant_controller_sequencer_tb.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// self-checking bench for the operating-state sequencer
module resonant_controller_sequencer_tb;
   localparam int unsigned BLANK = seq_pkg::BLANK_CYCLES; // bias-settle window
   logic clk;                     // 100 MHz clock
   logic reset_n;                 // synchronous reset, active low
   logic [15:0] vcc_mv;           // supply level seen by the model
   logic [15:0] bulk_mv;          // bulk level
   logic [15:0] fb_mv;            // feedback level
   logic [2:0] fault_req;         // severe, overload, overtemp
   logic off_mode_enable;         // off-mode option
   seq_pkg::supply_s supply_cmp;  // model to design
   seq_pkg::fault_s faults;       // model to design
   logic bulk_voltage_good, feedback_skip, feedback_exit, feedback_released;
   seq_pkg::enables_s enables;    // block enables
   logic [1:0] front_stage_enable_out;
   seq_pkg::state_e state_out;
   int errors;                    // mismatches
   int check_count;               // comparisons
   int starts;                    // soft-start pulses seen

   supply_fault_model supply_fault_model_inst (.vcc_mv(vcc_mv), .bulk_mv(bulk_mv),
      .fb_mv(fb_mv), .fault_req(fault_req), .supply_cmp(supply_cmp),
      .bulk_voltage_good(bulk_voltage_good), .feedback_skip(feedback_skip),
      .feedback_exit(feedback_exit), .feedback_released(feedback_released), .faults(faults));

   resonant_controller_sequencer #(.RECOVERY_DELAY(50)) resonant_controller_sequencer_inst (
      .clk(clk), .reset_n(reset_n), .supply_cmp(supply_cmp),
      .bulk_voltage_good(bulk_voltage_good), .feedback_skip(feedback_skip),
      .feedback_exit(feedback_exit), .feedback_released(feedback_released),
      .faults(faults), .off_mode_enable(off_mode_enable), .enables(enables),
      .front_stage_enable_out(front_stage_enable_out), .state_out(state_out));

   ////////////////////////////////////////////////////////////////////////////////
   // clock and soft-start pulse counter
   always #5 clk = ~clk;
   always @(posedge clk) begin
      if (enables.soft_start === 1'b1) starts++;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // shared helpers
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // waits a bounded time for a state, then compares it
   task automatic wait_state(input seq_pkg::state_e exp, input int max);
      int n;
      n = 0;
      while (state_out !== exp && n < max) begin
         @(negedge clk);
         n++;
      end
      check("state", state_out, exp);
   endtask
   // masked compare of {analog, severe_fault_input, startup, self_supply, bridge}
   task automatic en(input logic [4:0] exp, input logic [4:0] care);
      check("enables", {enables.analog_bias, enables.severe_fault_input_bias, enables.startup_source,
         enables.dynamic_self_supply, enables.bridge_enable} & care, exp & care);
   endtask
   // an input change shows on the outputs at the third edge, not before
   task automatic lat(input seq_pkg::state_e old_s, input seq_pkg::state_e new_s);
      cyc(2);
      check("state before sync", state_out, old_s);
      cyc(1);
      check("state after sync", state_out, new_s);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // start-up through brown-out wait
   task automatic t_start();
      vcc_mv = 16'h2710;
      wait_state(seq_pkg::ST_CHARGE, 10);
      en(5'b11100, 5'b11101);
      vcc_mv = 16'h32c8;
      cyc(BLANK - 100);
      check("blank hold", state_out, seq_pkg::ST_CHARGE);
      wait_state(seq_pkg::ST_WAIT_BULK, 200);
      en(5'b10010, 5'b10011);
      check("front", front_stage_enable_out, seq_pkg::FS_ON);
      bulk_mv = 16'h0190;
      wait_state(seq_pkg::ST_RECHARGE, 10);
      en(5'b10100, 5'b10101);
      cyc(BLANK - 100);
      check("recharge blank", state_out, seq_pkg::ST_RECHARGE);
      wait_state(seq_pkg::ST_RUN, 200);
      en(5'b10001, 5'b10001);
      cyc(1);
      check("soft starts", starts, 1);
      $display("test start done");
   endtask

   task automatic t_brownout();
      bulk_mv = 16'h00c8;
      lat(seq_pkg::ST_RUN, seq_pkg::ST_BROWNOUT);
      en(5'b00010, 5'b01011);
      check("front", front_stage_enable_out, seq_pkg::FS_ON);
      bulk_mv = 16'h0190;
      wait_state(seq_pkg::ST_RECHARGE, 10);
      wait_state(seq_pkg::ST_RUN, BLANK + 100);
      cyc(1);
      check("soft starts", starts, 2);
      $display("test brownout done");
   endtask

   // latched shutdown held until supply reset
   task automatic t_latch();
      fault_req = 3'h4;
      wait_state(seq_pkg::ST_LATCH, 10);
      en(5'b00010, 5'b11011);
      fault_req = 3'h0;
      cyc(100);
      check("latch held", state_out, seq_pkg::ST_LATCH);
      vcc_mv = 16'h1388;
      wait_state(seq_pkg::ST_POR, 10);
      check("front", front_stage_enable_out, seq_pkg::FS_OFF);
      vcc_mv = 16'h32c8;
      wait_state(seq_pkg::ST_RUN, BLANK + 100);
      $display("test latch done");
   endtask

   task automatic t_recover();
      fault_req = 3'h2;
      lat(seq_pkg::ST_RUN, seq_pkg::ST_RECOVER);
      fault_req = 3'h0;
      en(5'b00010, 5'b00011);
      cyc(40);
      check("delay runs", state_out, seq_pkg::ST_RECOVER);
      wait_state(seq_pkg::ST_CHARGE, 20);
      en(5'b11100, 5'b11101);
      wait_state(seq_pkg::ST_RUN, BLANK + 100);
      cyc(1);
      check("soft starts", starts, 4);
      $display("test recover done");
   endtask

   task automatic t_skip();
      fb_mv = 16'h012c;
      wait_state(seq_pkg::ST_SKIP, 10);
      en(5'b00000, 5'b11001);
      check("fb bias", enables.fb_supply_bias, 1'b1);
      fb_mv = 16'h02bc;
      wait_state(seq_pkg::ST_BURST, 10);
      en(5'b10001, 5'b10111);
      fault_req = 3'h1;
      cyc(500);
      check("ot masked", state_out, seq_pkg::ST_BURST);
      fault_req = 3'h0;
      bulk_mv = 16'h00c8;
      wait_state(seq_pkg::ST_BROWNOUT, 10);
      en(5'b00010, 5'b01011);
      check("front", front_stage_enable_out, seq_pkg::FS_HOLD);
      bulk_mv = 16'h0190;
      wait_state(seq_pkg::ST_RUN, BLANK + 100);
      $display("test skip done");
   endtask

   task automatic t_offmode();
      off_mode_enable = 1'b1;
      fb_mv = 16'h012c;
      wait_state(seq_pkg::ST_SKIP, 10);
      vcc_mv = 16'h2134;
      wait_state(seq_pkg::ST_OFFMODE, 10);
      en(5'b00010, 5'b00011);
      fb_mv = 16'h07d0;
      wait_state(seq_pkg::ST_CHARGE, 10);
      en(5'b00100, 5'b00101);
      vcc_mv = 16'h32c8;
      wait_state(seq_pkg::ST_RUN, BLANK + 100);
      // brown-out from run after an earlier skip stop keeps the plain level
      bulk_mv = 16'h00c8;
      lat(seq_pkg::ST_RUN, seq_pkg::ST_BROWNOUT);
      check("front after run", front_stage_enable_out, seq_pkg::FS_ON);
      $display("test offmode done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // verdict and end of run
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // watchdog sized well above the expected run
   initial begin
      repeat (60000) @(posedge clk);
      errors++;
      results();
   end

   // main sequence
   initial begin
      clk = 1'b0;
      reset_n = 1'b0;
      vcc_mv = 16'h0000;
      bulk_mv = 16'h00c8;
      fb_mv = 16'h03e8;
      fault_req = 3'h0;
      off_mode_enable = 1'b0;
      errors = 0;
      check_count = 0;
      starts = 0;
      cyc(3);
      reset_n = 1'b1;
      t_start();
      t_brownout();
      t_latch();
      t_recover();
      t_skip();
      t_offmode();
      results();
   end
endmodule // resonant_controller_sequencer_tb
